// ===== iesc_top.sv
// Interrupt enable set/clear register block with APB slave port.
// Assumes an APB master on pclk and interrupt request lines from
// outside this clock domain.
//
// Contract
// - Set word 4 bits 3 and 2 enable interrupts 99 and 98.
// - Writing one to a set view bit enables; zero leaves it alone.
// - Reading a set view returns current enable state per interrupt.
// - Clear word 1 bits 30 to 14 map to interrupts 30 to 14.
// - Clear word 1 bits 7 to 0 map to interrupts 7 to 0.
// - Writing one to a clear view bit disables; zero leaves it alone.
// - Reading a clear view also returns current enable state.
//
// The placing of the registers and register access over APB are this design's own decisions.
`default_nettype none

module iesc_top
	import iesc_pkg::*;
#(
	parameter int NUM_WORDS = IESC_WORDS
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [IESC_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [IESC_NUM_IRQ-1:0] irq_req,
	output logic      [IESC_NUM_IRQ-1:0] irq_enable,
	output logic      [IESC_NUM_IRQ-1:0] irq_active
);

	iesc_top_s state_r;
	iesc_top_s state_nxt;

	logic [1:0]             word_idx;
	logic                   idx_ok;
	logic                   hit_set;
	logic                   hit_clr;
	logic                   access;
	logic                   commit;
	logic [NUM_WORDS-1:0]   set_we;
	logic [NUM_WORDS-1:0]   clr_we;
	logic [NUM_WORDS-1:0][31:0] en_word;
	logic [31:0]            rd_word;

	// ==========================================================
	// Address decode
	// Bit 4 of the index must be zero, so only words 0..3 exist
	assign word_idx = paddr[IESC_IDX_MSB-1:IESC_IDX_LSB];
	assign idx_ok   = (paddr[IESC_IDX_MSB] == 1'b0);
	assign hit_set  = idx_ok && ((paddr & IESC_VIEW_MASK) == IESC_SET_BASE);
	assign hit_clr  = idx_ok && ((paddr & IESC_VIEW_MASK) == IESC_CLR_BASE);
	assign access   = psel && penable;
	// One wait state: the transfer completes when pready is already high
	assign commit   = access && state_r.pready;

	// ==========================================================
	// Write strobes, one per word and view
	always_comb begin
		set_we = '0;
		clr_we = '0;
		if (commit && pwrite && !state_r.pslverr) begin
			set_we[word_idx] = hit_set;
			clr_we[word_idx] = hit_clr;
		end
	end

	// ==========================================================
	// Enable storage, word w holds interrupts 32*w .. 32*w+31
	for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
		iesc_enable_word #(
			.IMPL_MASK (IESC_IMPL_MASK[w])
		) u_word (
			.pclk      (pclk),
			.presetn   (presetn),
			.set_we    (set_we[w]),
			.clr_we    (clr_we[w]),
			.wdata     (pwdata),
			.en        (en_word[w])
		);
		assign irq_enable[32*w +: 32] = en_word[w];
	end

	// ==========================================================
	// Read view, identical for set and clear addresses
	always_comb begin
		rd_word = IESC_RD_RESET;
		if (hit_set || hit_clr) begin
			rd_word = en_word[word_idx];
		end
	end

	// ==========================================================
	// Next state: bus answer and request qualification
	always_comb begin
		state_nxt = state_r;

		// Bus answer, prepared during the first access cycle
		if (access && !state_r.pready) begin
			state_nxt.pready  = 1'b1;
			state_nxt.pslverr = !(hit_set || hit_clr);
			state_nxt.prdata  = (!pwrite) ? rd_word : IESC_RD_RESET;
		end else begin
			state_nxt.pready  = 1'b0;
			state_nxt.pslverr = 1'b0;
			state_nxt.prdata  = IESC_RD_RESET;
		end

		// Requests arrive asynchronously; accept a level once two stages agree
		state_nxt.req_s1 = irq_req;
		state_nxt.req_s2 = state_r.req_s1;
		state_nxt.req_s3 = state_r.req_s2;
		for (int i = 0; i < IESC_NUM_IRQ; i++) begin
			if (state_r.req_s2[i] == state_r.req_s3[i]) begin
				state_nxt.req_stable[i] = state_r.req_s3[i];
			end
		end

		// A disabled interrupt stops reaching the core one cycle after its enable clears
		state_nxt.req_active = state_r.req_stable & irq_enable;
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r.prdata     <= IESC_RD_RESET;
			state_r.pready     <= 1'b0;
			state_r.pslverr    <= 1'b0;
			state_r.req_s1     <= '0;
			state_r.req_s2     <= '0;
			state_r.req_s3     <= '0;
			state_r.req_stable <= '0;
			state_r.req_active <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata     = state_r.prdata;
	assign pready     = state_r.pready;
	assign pslverr    = state_r.pslverr;
	assign irq_active = state_r.req_active;

endmodule : iesc_top

`default_nettype wire

// ===== iesc_pkg.sv
// Package for the interrupt enable set/clear register block.
// Assumes one APB clock domain; all offsets are byte addresses.
`default_nettype none

package iesc_pkg;

	// ==========================================================
	// Geometry
	localparam int IESC_WORDS       = 4;
	localparam int IESC_DATA_W      = 32;
	localparam int IESC_ADDR_W      = 12;
	localparam int IESC_NUM_IRQ     = IESC_WORDS * IESC_DATA_W;

	// ==========================================================
	// Register map
	localparam logic [11:0] IESC_SET_BASE   = 12'h000;
	localparam logic [11:0] IESC_CLR_BASE   = 12'h020;
	localparam logic [11:0] IESC_VIEW_MASK  = 12'hFE0;
	localparam int          IESC_IDX_LSB    = 2;
	localparam int          IESC_IDX_MSB    = 4;

	// ==========================================================
	// Implemented enable positions per word (word 1 first)
	localparam logic [31:0] IESC_IMPL_W1    = 32'h7FFFC0FF;
	localparam logic [31:0] IESC_IMPL_W2    = 32'h0CFFFFEF;
	localparam logic [31:0] IESC_IMPL_W3    = 32'h00FF3C00;
	localparam logic [31:0] IESC_IMPL_W4    = 32'h0000000C;
	localparam logic [IESC_WORDS-1:0][31:0] IESC_IMPL_MASK =
		{IESC_IMPL_W4, IESC_IMPL_W3, IESC_IMPL_W2, IESC_IMPL_W1};

	// ==========================================================
	// Reset values
	localparam logic [31:0] IESC_EN_RESET   = 32'h00000000;
	localparam logic [31:0] IESC_RD_RESET   = 32'h00000000;

	// ==========================================================
	// State types
	typedef struct packed {
		logic [31:0] en;
	} iesc_word_s;

	typedef struct packed {
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic [IESC_NUM_IRQ-1:0] req_s1;
		logic [IESC_NUM_IRQ-1:0] req_s2;
		logic [IESC_NUM_IRQ-1:0] req_s3;
		logic [IESC_NUM_IRQ-1:0] req_stable;
		logic [IESC_NUM_IRQ-1:0] req_active;
	} iesc_top_s;

endpackage : iesc_pkg

`default_nettype wire

// ===== iesc_enable_word.sv
// One 32-bit word of interrupt enable flip-flops.
// Assumes set and clear strobes are one-cycle pulses in the pclk domain.
`default_nettype none

module iesc_enable_word
	import iesc_pkg::*;
#(
	parameter logic [31:0] IMPL_MASK = 32'hFFFFFFFF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        set_we,
	input  wire logic        clr_we,
	input  wire logic [31:0] wdata,
	output logic      [31:0] en
);

	iesc_word_s state_r;
	iesc_word_s state_nxt;

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		for (int b = 0; b < 32; b++) begin
			if (!IMPL_MASK[b]) begin
				state_nxt.en[b] = 1'b0;
			end else if (set_we && wdata[b]) begin
				state_nxt.en[b] = 1'b1;
			end else if (clr_we && wdata[b]) begin
				state_nxt.en[b] = 1'b0;
			end
		end
	end

	// ==========================================================
	// Storage, one flop per interrupt shared by both views
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r.en <= IESC_EN_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign en = state_r.en;

endmodule : iesc_enable_word

`default_nettype wire

// ===== iesc_checker_props.sv
// Port assertions for the enable set/clear block.
// Assumes a bind onto iesc_top, one pclk domain.
`default_nettype none
module iesc_checker
	import iesc_pkg::*;
(
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [IESC_ADDR_W-1:0]  paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic [IESC_NUM_IRQ-1:0] irq_req,
	input wire logic [IESC_NUM_IRQ-1:0] irq_enable,
	input wire logic [IESC_NUM_IRQ-1:0] irq_active
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Helpers
	wire logic [1:0]   w = paddr[3:2];
	wire logic         done = psel && penable && pready;
	wire logic         rd = done && !pwrite;
	wire logic         set_wr = done && pwrite && paddr[11:4] == 8'h00;
	wire logic         clr_wr = done && pwrite && paddr[11:4] == 8'h02;
	wire logic [31:0]  cur = irq_enable[{w, 5'h00} +: 32];
	wire logic [127:0] sh = {96'h0, pwdata & IESC_IMPL_MASK[w]} << {w, 5'h00};
	wire logic [127:0] exp_set = irq_enable | sh;
	wire logic [127:0] exp_clr = irq_enable & ~sh;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence access_wait;
		psel && penable && !pready ##1 pready;
	endsequence
	// ==========
	// Properties
	chk_one_wait: assert property ($rose(penable) && psel |-> access_wait)
		else $error("pready not after one wait");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_active_gate: assert property ((irq_active & ~$past(irq_enable)) == '0)
		else $error("disabled request active");
	chk_set_on: assert property (set_wr |=> irq_enable == $past(exp_set))
		else $error("set write wrong");
	chk_clr_off: assert property (clr_wr |=> irq_enable == $past(exp_clr))
		else $error("clear write wrong");
	chk_idle_hold: assert property (!(set_wr || clr_wr) |=> $stable(irq_enable))
		else $error("enable moved");
	chk_unimpl_zero: assert property ((irq_enable & ~IESC_IMPL_MASK) == '0)
		else $error("unused enable set");
	chk_set_read: assert property (rd && paddr[11:4] == 8'h00 |-> prdata == cur)
		else $error("set view read wrong");
	chk_clr_read: assert property (rd && paddr[11:4] == 8'h02 |-> prdata == cur)
		else $error("clear view read wrong");
	chk_word4_pair: assert property (set_wr && w == 2'h3 |=> irq_enable[99:98] ==
		($past(irq_enable[99:98]) | $past(pwdata[3:2]))) else $error("word4 pair wrong");
	chk_word1_clr: assert property (clr_wr && w == 2'h0 |=>
		(irq_enable[30:14] & $past(pwdata[30:14])) == '0 &&
		(irq_enable[7:0] & $past(pwdata[7:0])) == '0) else $error("word1 clear wrong");
endmodule : iesc_checker
`default_nettype wire

// ===== iesc_bench.sv
// Self-checking bench for the enable set/clear block.
// Assumes iesc_top and the checker are compiled first.
`default_nettype none
module iesc_bench
	import iesc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0, prdata, q;
	logic [127:0] irq_req = 128'h0, irq_enable, irq_active;
	logic         pready, pslverr, e;
	int           n_fail = 0, n_checks = 0;
	always #5 pclk = ~pclk;
	iesc_top iesc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_req(irq_req), .irq_enable(irq_enable), .irq_active(irq_active));
	// ==========
	// Tasks
	task automatic conclude();
		if (n_fail == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	task automatic check(string nm, logic [127:0] s, logic [127:0] x);
		n_checks++;
		if (s !== x) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, x, s);
		end
	endtask : check
	// Idle cycle between transfers keeps strobes single-driven
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			conclude();
		end
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// ==========
	// Sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int w = 0; w < 4; w++) begin
			apb(1'b0, 12'(4 * w), 32'h0);
			check("reset", q, 32'h0);
			check("no err", e, 1'b0);
			apb(1'b1, 12'(4 * w), 32'hFFFFFFFF);
			apb(1'b0, 12'(4 * w), 32'h0);
			check("set view", q, IESC_IMPL_MASK[w]);
			apb(1'b1, 12'(32 + 4 * w), 32'h0);
			apb(1'b0, 12'(32 + 4 * w), 32'h0);
			check("clear view", q, IESC_IMPL_MASK[w]);
			apb(1'b1, 12'(32 + 4 * w), 32'hFFFFFFFF);
			apb(1'b0, 12'(4 * w), 32'h0);
			check("cleared", q, 32'h0);
		end
		apb(1'b1, 12'h00C, 32'h00000004);
		apb(1'b1, 12'h00C, 32'h00000000);
		apb(1'b0, 12'h00C, 32'h0);
		check("word4", irq_enable[99:98], 2'b01);
		check("word4 read", q, 32'h00000004);
		apb(1'b1, 12'h02C, 32'h00000004);
		apb(1'b1, 12'h000, 32'hFFFFFFFF);
		check("word4 clear", irq_enable[99:98], 2'b00);
		apb(1'b1, 12'h020, 32'h40004081);
		apb(1'b0, 12'h020, 32'h0);
		check("word1", irq_enable[31:0], IESC_IMPL_W1 & ~32'h40004081);
		check("word1 read", q, IESC_IMPL_W1 & ~32'h40004081);
		apb(1'b1, 12'h030, 32'hFFFFFFFF);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped err", e, 1'b1);
		check("unmapped data", q, 32'h0);
		check("unmapped write", irq_enable[127:32], 96'h0);
		irq_req <= '1;
		for (int i = 0; i < 20 && irq_active !== irq_enable; i++) @(posedge pclk);
		check("active", irq_active, {96'h0, IESC_IMPL_W1 & ~32'h40004081});
		// Mid-run reset must clear every enable flop
		presetn <= 1'b0;
		@(posedge pclk);
		check("reset again", irq_enable, 128'h0);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		check("after reset", q, 32'h0);
		conclude();
	end
endmodule : iesc_bench
bind iesc_top iesc_checker iesc_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_enable(irq_enable),
	.irq_active(irq_active));
`default_nettype wire
